//--- shared/fre_params.svh
// offsets, field positions, reset values and timing figures of the frequency element
`ifndef FRE_PARAMS_SVH
`define FRE_PARAMS_SVH
`define FRE_ADR_CTRL 6'h00
`define FRE_ADR_UNDER 6'h01
`define FRE_ADR_OVER 6'h02
`define FRE_ADR_GRAD 6'h03
`define FRE_ADR_VMIN 6'h04
`define FRE_ADR_DELAY 6'h05
`define FRE_ADR_CHANGE 6'h06
`define FRE_ADR_INTERVAL 6'h07
`define FRE_ADR_SURGE 6'h08
`define FRE_ADR_STATUS 6'h09
`define FRE_CTRL_MODE_LSB 0
`define FRE_CTRL_DIR_LSB 3
`define FRE_CTRL_NEED_LSB 5
`define FRE_CTRL_SBLK_BIT 7
`define FRE_CTRL_WIN_LSB 8
`define FRE_RST_CTRL 12'h200
`define FRE_RST_THR 16'h0000
`define FRE_RST_SURGE 24'hffffff
`define FRE_WIN_MIN 4'h2
`define FRE_WIN_MAX 4'ha
`define FRE_CLK_HZ 100000000
`define FRE_TICK_MS 1
`define FRE_DETECT_MS 60
`endif

//--- shared/fre_pkg.sv
// types of the frequency element
package fre_pkg;
   typedef enum logic [2:0] {FRE_OFF, FRE_UF_GRAD, FRE_OF_GRAD, FRE_UF_CHG, FRE_OF_CHG, FRE_SURGE} fre_mode_t;
   typedef enum logic [1:0] {FRE_DIR_POS, FRE_DIR_NEG, FRE_DIR_ABS} fre_dir_t;
   typedef enum logic [1:0] {FRE_ST_IDLE, FRE_ST_RUN, FRE_ST_TRIP, FRE_ST_LOCK} fre_state_t;
endpackage : fre_pkg

//--- shared/fre_surge_if.sv
// link between the element and its cycle duration checker
`timescale 1ns/1ps
`default_nettype none
interface fre_surge_if #(parameter int DW = 24);
   logic [2:0] zc;
   logic lockout;
   logic [DW-1:0] thr;
   logic [2:0] exceed;
   modport main (output zc, output lockout, output thr, input exceed);
   modport surge (input zc, input lockout, input thr, output exceed);
endinterface : fre_surge_if
`default_nettype wire

//--- hw/fre_surge.sv
// cycle duration measurement and deviation check for three phases
`timescale 1ns/1ps
`default_nettype none
module fre_surge #(
   parameter int DW = 24,
   parameter int DETECT_CYC = 6000000
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // element side
   fre_surge_if.surge sif
);
   localparam logic [DW-1:0] DET = DW'(DETECT_CYC);
   logic [DW-1:0] cnt_ff [3];
   logic [DW-1:0] ref_ff [3];
   logic [2:0] exc_ff;
   logic [2:0] valid_ff;
   logic [DW-1:0] nxt_cnt [3];
   logic [DW-1:0] nxt_ref [3];
   logic [2:0] nxt_exc;
   logic [2:0] nxt_valid;
   logic [DW-1:0] dev;

   assign sif.exceed = exc_ff;

   always_comb begin
      dev = '0;
      for (int p = 0; p < 3; p++) begin
         nxt_cnt[p] = cnt_ff[p];
         nxt_ref[p] = ref_ff[p];
         nxt_exc[p] = exc_ff[p];
         nxt_valid[p] = valid_ff[p];
         if (sif.lockout) begin
            nxt_cnt[p] = '0;
            nxt_exc[p] = 1'b0;
            nxt_valid[p] = 1'b0;
         end else if (sif.zc[p]) begin
            // previous cycle is the reference, slow drift cancels out
            dev = (cnt_ff[p] > ref_ff[p]) ? cnt_ff[p] - ref_ff[p] : ref_ff[p] - cnt_ff[p];
            nxt_exc[p] = valid_ff[p] && (dev > sif.thr);
            nxt_ref[p] = cnt_ff[p];
            nxt_valid[p] = 1'b1;
            nxt_cnt[p] = DW'(1);
         end else if (cnt_ff[p] >= DET) begin
            // no zero crossing within the detection time means mains failure
            nxt_exc[p] = valid_ff[p];
         end else begin
            nxt_cnt[p] = cnt_ff[p] + DW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int p = 0; p < 3; p++) begin
            cnt_ff[p] <= '0;
            ref_ff[p] <= '0;
         end
         exc_ff <= 3'h0;
         valid_ff <= 3'h0;
      end else begin
         cnt_ff <= nxt_cnt;
         ref_ff <= nxt_ref;
         exc_ff <= nxt_exc;
         valid_ff <= nxt_valid;
      end
   end

   property p_restart;
      @(posedge clk) disable iff (srst) (sif.zc[0] && !sif.lockout) |=> cnt_ff[0] == DW'(1);
   endproperty
   a_restart: assert property (p_restart) else $error("cycle count not restarted at zero crossing");
endmodule : fre_surge
`default_nettype wire

//--- hw/fre_element.sv
// frequency protection element with gradient, interval change and vector surge modes
`include "fre_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fre_element #(
   parameter int TICK_CYC = `FRE_CLK_HZ / 1000 * `FRE_TICK_MS,
   parameter int DETECT_CYC = `FRE_CLK_HZ / 1000 * `FRE_DETECT_MS,
   parameter int WIN_MAX = 10
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // measurements
   input wire logic [15:0] FREQ_A_B,
   input wire logic [15:0] FREQ_B_C,
   input wire logic [15:0] FREQ_C_A,
   input wire logic [15:0] VOLT_PHASE_A_B,
   input wire logic [15:0] VOLT_PHASE_B_C,
   input wire logic [15:0] VOLT_PHASE_C_A,
   input wire logic [2:0] ZERO_CROSS,
   // blocking and outputs
   input wire logic EXT_BLOCK,
   output logic ALARM,
   output logic TRIP
);
   // ************************************
   // helpers
   // ************************************
   function automatic logic [31:0] wr_lanes(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction : wr_lanes

   function automatic logic grad_hit(input logic signed [16:0] d, input logic [19:0] lim, input logic [1:0] dir);
      logic signed [20:0] l;
      logic signed [20:0] x;
      l = $signed({1'b0, lim});
      x = 21'(d);
      unique case (dir)
         fre_pkg::FRE_DIR_POS: return x > l;
         fre_pkg::FRE_DIR_NEG: return -x > l;
         default: return (x > l) || (-x > l);
      endcase
   endfunction : grad_hit

   function automatic logic [1:0] count3(input logic [2:0] v);
      return 2'({1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]});
   endfunction : count3

   // ************************************
   // register file
   // ************************************
   logic [11:0] ctrl_ff;
   logic [15:0] under_ff, over_ff, gthr_ff, vmin_ff, delay_ff, change_ff, interval_ff;
   logic [23:0] surge_ff;
   logic [31:0] dat_ff;
   logic ack_ff;
   logic [11:0] nxt_ctrl;
   logic [15:0] nxt_under, nxt_over, nxt_gthr, nxt_vmin, nxt_delay, nxt_change, nxt_interval;
   logic [23:0] nxt_surge;
   logic [31:0] nxt_dat;
   logic nxt_ack;
   logic [31:0] status;
   logic [31:0] cur_word;
   logic [31:0] wr_word;
   logic req;

   assign WB_DAT_O = dat_ff;
   assign WB_ACK_O = ack_ff;
   assign req = WB_CYC_I && WB_STB_I && !ack_ff;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_under = under_ff;
      nxt_over = over_ff;
      nxt_gthr = gthr_ff;
      nxt_vmin = vmin_ff;
      nxt_delay = delay_ff;
      nxt_change = change_ff;
      nxt_interval = interval_ff;
      nxt_surge = surge_ff;
      nxt_dat = dat_ff;
      nxt_ack = req;
      cur_word = 32'h0;
      unique case (WB_ADR_I[7:2])
         `FRE_ADR_CTRL: cur_word = {20'h0, ctrl_ff};
         `FRE_ADR_UNDER: cur_word = {16'h0, under_ff};
         `FRE_ADR_OVER: cur_word = {16'h0, over_ff};
         `FRE_ADR_GRAD: cur_word = {16'h0, gthr_ff};
         `FRE_ADR_VMIN: cur_word = {16'h0, vmin_ff};
         `FRE_ADR_DELAY: cur_word = {16'h0, delay_ff};
         `FRE_ADR_CHANGE: cur_word = {16'h0, change_ff};
         `FRE_ADR_INTERVAL: cur_word = {16'h0, interval_ff};
         `FRE_ADR_SURGE: cur_word = {8'h0, surge_ff};
         `FRE_ADR_STATUS: cur_word = status;
         default: ;
      endcase
      wr_word = wr_lanes(cur_word, WB_DAT_I, WB_SEL_I);
      if (req && WB_WE_I) begin
         unique case (WB_ADR_I[7:2])
            `FRE_ADR_CTRL: nxt_ctrl = wr_word[11:0];
            `FRE_ADR_UNDER: nxt_under = wr_word[15:0];
            `FRE_ADR_OVER: nxt_over = wr_word[15:0];
            `FRE_ADR_GRAD: nxt_gthr = wr_word[15:0];
            `FRE_ADR_VMIN: nxt_vmin = wr_word[15:0];
            `FRE_ADR_DELAY: nxt_delay = wr_word[15:0];
            `FRE_ADR_CHANGE: nxt_change = wr_word[15:0];
            `FRE_ADR_INTERVAL: nxt_interval = wr_word[15:0];
            `FRE_ADR_SURGE: nxt_surge = wr_word[23:0];
            default: ;
         endcase
      end
      if (req) begin
         nxt_dat = cur_word;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_ff <= `FRE_RST_CTRL;
         under_ff <= `FRE_RST_THR;
         over_ff <= `FRE_RST_THR;
         gthr_ff <= `FRE_RST_THR;
         vmin_ff <= `FRE_RST_THR;
         delay_ff <= `FRE_RST_THR;
         change_ff <= `FRE_RST_THR;
         interval_ff <= `FRE_RST_THR;
         surge_ff <= `FRE_RST_SURGE;
         dat_ff <= 32'h0;
         ack_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         under_ff <= nxt_under;
         over_ff <= nxt_over;
         gthr_ff <= nxt_gthr;
         vmin_ff <= nxt_vmin;
         delay_ff <= nxt_delay;
         change_ff <= nxt_change;
         interval_ff <= nxt_interval;
         surge_ff <= nxt_surge;
         dat_ff <= nxt_dat;
         ack_ff <= nxt_ack;
      end
   end

   // ************************************
   // settings and phase conditions
   // ************************************
   fre_pkg::fre_mode_t mode;
   logic [1:0] dir;
   logic [1:0] need;
   logic [3:0] win;
   logic [15:0] freq [3];
   logic [15:0] volt [3];
   logic [2:0] vlow, beyond, gok, pick, chg, surge_exc;
   logic freq_block, phase_loss, blocked, is_grad, is_chg, is_under, surge_ok;
   logic [15:0] hist_ff [3][WIN_MAX];
   logic signed [16:0] grad_ff [3];
   logic [15:0] nxt_hist [3][WIN_MAX];
   logic signed [16:0] nxt_grad [3];
   logic [15:0] fstart_ff [3];
   logic [15:0] nxt_fstart [3];

   // unknown mode codes fall back to off
   assign mode = (ctrl_ff[`FRE_CTRL_MODE_LSB +: 3] > 3'h5) ? fre_pkg::FRE_OFF :
                 fre_pkg::fre_mode_t'(ctrl_ff[`FRE_CTRL_MODE_LSB +: 3]);
   assign dir = ctrl_ff[`FRE_CTRL_DIR_LSB +: 2];
   assign need = ctrl_ff[`FRE_CTRL_NEED_LSB +: 2];
   // clamp window to its legal span
   assign win = (ctrl_ff[`FRE_CTRL_WIN_LSB +: 4] < `FRE_WIN_MIN) ? `FRE_WIN_MIN :
                (ctrl_ff[`FRE_CTRL_WIN_LSB +: 4] > `FRE_WIN_MAX) ? `FRE_WIN_MAX : ctrl_ff[`FRE_CTRL_WIN_LSB +: 4];
   assign freq = '{FREQ_A_B, FREQ_B_C, FREQ_C_A};
   assign volt = '{VOLT_PHASE_A_B, VOLT_PHASE_B_C, VOLT_PHASE_C_A};
   assign is_grad = (mode == fre_pkg::FRE_UF_GRAD) || (mode == fre_pkg::FRE_OF_GRAD);
   assign is_chg = (mode == fre_pkg::FRE_UF_CHG) || (mode == fre_pkg::FRE_OF_CHG);
   assign is_under = (mode == fre_pkg::FRE_UF_GRAD) || (mode == fre_pkg::FRE_UF_CHG);
   assign blocked = EXT_BLOCK || ctrl_ff[`FRE_CTRL_SBLK_BIT];
   assign freq_block = &vlow;
   assign phase_loss = |vlow;

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         vlow[p] = volt[p] < vmin_ff;
         beyond[p] = is_under ? (freq[p] < under_ff) : (freq[p] > over_ff);
         gok[p] = grad_hit(grad_ff[p], 20'(gthr_ff) * 20'(win), dir);
         pick[p] = beyond[p] && gok[p];
         chg[p] = is_under ? ({1'b0, fstart_ff[p]} >= {1'b0, freq[p]} + {1'b0, change_ff}) :
                  ({1'b0, freq[p]} >= {1'b0, fstart_ff[p]} + {1'b0, change_ff});
         nxt_grad[p] = grad_ff[p];
         for (int k = 0; k < WIN_MAX; k++) begin
            nxt_hist[p][k] = hist_ff[p][k];
         end
         if (ZERO_CROSS[p]) begin
            // gradient over the window, one fresh value per period
            nxt_grad[p] = $signed({1'b0, freq[p]}) - $signed({1'b0, hist_ff[p][win - 4'h1]});
            nxt_hist[p][0] = freq[p];
            for (int k = 1; k < WIN_MAX; k++) begin
               nxt_hist[p][k] = hist_ff[p][k-1];
            end
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         for (int p = 0; p < 3; p++) begin
            grad_ff[p] <= '0;
            for (int k = 0; k < WIN_MAX; k++) begin
               hist_ff[p][k] <= 16'h0;
            end
         end
      end else begin
         grad_ff <= nxt_grad;
         hist_ff <= nxt_hist;
      end
   end

   // ************************************
   // vector surge checker
   // ************************************
   fre_surge_if #(.DW(24)) sif ();
   assign sif.zc = ZERO_CROSS;
   assign sif.lockout = phase_loss || (mode != fre_pkg::FRE_SURGE);
   assign sif.thr = surge_ff;
   assign surge_exc = sif.exceed;

   fre_surge #(.DW(24), .DETECT_CYC(DETECT_CYC)) u_surge (
      .clk(MCLK),
      .srst(SRST),
      .sif(sif)
   );

   // phases needed: 0 any one, 1 two, else all three
   assign surge_ok = (mode == fre_pkg::FRE_SURGE) && !blocked && !phase_loss &&
                     (count3(surge_exc) >= ((need == 2'h0) ? 2'h1 : (need == 2'h1) ? 2'h2 : 2'h3));

   // ************************************
   // timers and state machine
   // ************************************
   fre_pkg::fre_state_t state_ff, nxt_state;
   logic [$clog2(TICK_CYC+1)-1:0] pre_ff, nxt_pre;
   logic [15:0] timer_ff, nxt_timer;
   logic alarm_ff, trip_ff, nxt_alarm, nxt_trip, tick;

   assign tick = pre_ff == ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
   assign ALARM = alarm_ff;
   assign TRIP = trip_ff;
   assign status = {21'h0, pick, surge_exc, state_ff == fre_pkg::FRE_ST_LOCK, phase_loss, freq_block, trip_ff, alarm_ff};

   always_comb begin
      nxt_pre = tick ? '0 : pre_ff + 1'b1;
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      nxt_fstart = fstart_ff;
      if (!(is_grad || is_chg)) begin
         nxt_state = fre_pkg::FRE_ST_IDLE;
         nxt_timer = 16'h0;
      end else if ((blocked || freq_block) && state_ff != fre_pkg::FRE_ST_LOCK) begin
         nxt_state = fre_pkg::FRE_ST_IDLE;
         nxt_timer = 16'h0;
      end else begin
         unique case (state_ff)
            fre_pkg::FRE_ST_IDLE: begin
               nxt_timer = 16'h0;
               if (is_grad && |pick) begin
                  nxt_state = fre_pkg::FRE_ST_RUN;
               end else if (is_chg && |beyond) begin
                  nxt_state = fre_pkg::FRE_ST_RUN;
                  nxt_fstart = freq;
               end
            end
            fre_pkg::FRE_ST_RUN: begin
               if (is_grad ? !(|pick) : !(|beyond)) begin
                  nxt_state = fre_pkg::FRE_ST_IDLE;
                  nxt_timer = 16'h0;
               end else if (is_grad && timer_ff >= delay_ff) begin
                  nxt_state = fre_pkg::FRE_ST_TRIP;
               end else if (is_chg && |(beyond & chg)) begin
                  nxt_state = fre_pkg::FRE_ST_TRIP;
               end else if (is_chg && timer_ff >= interval_ff) begin
                  nxt_state = fre_pkg::FRE_ST_LOCK;
               end else if (tick) begin
                  nxt_timer = timer_ff + 16'h1;
               end
            end
            fre_pkg::FRE_ST_TRIP: begin
               if (is_grad ? !(|pick) : !(|beyond)) begin
                  nxt_state = fre_pkg::FRE_ST_IDLE;
                  nxt_timer = 16'h0;
               end
            end
            fre_pkg::FRE_ST_LOCK: begin
               nxt_timer = 16'h0;
               if (!(|beyond)) begin
                  nxt_state = fre_pkg::FRE_ST_IDLE;
               end
            end
         endcase
      end
      // selected mode alone drives the outputs
      if (mode == fre_pkg::FRE_SURGE) begin
         nxt_alarm = surge_ok;
         nxt_trip = surge_ok;
      end else begin
         nxt_alarm = !blocked && (nxt_state == fre_pkg::FRE_ST_RUN || nxt_state == fre_pkg::FRE_ST_TRIP);
         nxt_trip = !blocked && nxt_state == fre_pkg::FRE_ST_TRIP;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state_ff <= fre_pkg::FRE_ST_IDLE;
         pre_ff <= '0;
         timer_ff <= 16'h0;
         alarm_ff <= 1'b0;
         trip_ff <= 1'b0;
         for (int p = 0; p < 3; p++) begin
            fstart_ff[p] <= 16'h0;
         end
      end else begin
         state_ff <= nxt_state;
         pre_ff <= nxt_pre;
         timer_ff <= nxt_timer;
         alarm_ff <= nxt_alarm;
         trip_ff <= nxt_trip;
         fstart_ff <= nxt_fstart;
      end
   end

   // ************************************
   // checks
   // ************************************
   property p_block;
      @(posedge MCLK) disable iff (SRST) blocked |=> !alarm_ff && !trip_ff;
   endproperty
   a_block: assert property (p_block) else $error("output active while blocked");

   property p_fblock;
      @(posedge MCLK) disable iff (SRST) (freq_block && mode != fre_pkg::FRE_SURGE) |=> !alarm_ff;
   endproperty
   a_fblock: assert property (p_fblock) else $error("alarm with all voltages low");

   property p_grad_alarm;
      @(posedge MCLK) disable iff (SRST)
         (is_grad && state_ff == fre_pkg::FRE_ST_IDLE && |pick && !blocked && !freq_block) |=> alarm_ff && !trip_ff;
   endproperty
   a_grad_alarm: assert property (p_grad_alarm) else $error("no instant alarm on pickup");

   property p_grad_trip;
      @(posedge MCLK) disable iff (SRST)
         (is_grad && $rose(trip_ff)) |-> $past(|pick) && $past(timer_ff) >= $past(delay_ff);
   endproperty
   a_grad_trip: assert property (p_grad_trip) else $error("trip without pickup at delay expiry");

   property p_lock;
      @(posedge MCLK) disable iff (SRST) state_ff == fre_pkg::FRE_ST_LOCK |-> !trip_ff && !alarm_ff;
   endproperty
   a_lock: assert property (p_lock) else $error("output while locked after interval");

   property p_rearm;
      @(posedge MCLK) disable iff (SRST)
         (state_ff == fre_pkg::FRE_ST_LOCK && |beyond && !(!(is_grad || is_chg))) |=> state_ff == fre_pkg::FRE_ST_LOCK;
   endproperty
   a_rearm: assert property (p_rearm) else $error("rearmed without fresh crossing");

   property p_surge_pair;
      @(posedge MCLK) disable iff (SRST) (mode == fre_pkg::FRE_SURGE) |=> alarm_ff == trip_ff;
   endproperty
   a_surge_pair: assert property (p_surge_pair) else $error("surge alarm and trip differ");

   property p_phase_loss;
      @(posedge MCLK) disable iff (SRST) (phase_loss && mode == fre_pkg::FRE_SURGE) |=> !trip_ff;
   endproperty
   a_phase_loss: assert property (p_phase_loss) else $error("surge trip with a phase lost");

   property p_drop;
      @(posedge MCLK) disable iff (SRST)
         (is_grad && state_ff == fre_pkg::FRE_ST_RUN && !(|pick)) |=> state_ff == fre_pkg::FRE_ST_IDLE && timer_ff == 16'h0;
   endproperty
   a_drop: assert property (p_drop) else $error("pickup drop did not clear timer");
endmodule : fre_element
`default_nettype wire

//--- test/fre_meas_model.sv
// measurement front end model: frequency, voltage and zero crossings
`timescale 1ns/1ps
`default_nettype none
module fre_meas_model (
   // clock
   input wire logic clk,
   // settings from the bench
   input wire logic [15:0] per,
   input wire logic [15:0] step,
   input wire logic [15:0] volt,
   // measurements
   output logic [15:0] freq,
   output logic [15:0] vout,
   output logic [2:0] zc
);
   logic [15:0] cnt = 16'h0000;
   logic [15:0] freq_ff = 16'h1000;
   logic [2:0] zc_ff = 3'h0;
   assign vout = volt;
   assign freq = freq_ff;
   assign zc = zc_ff;
   // one crossing on all phases per period, frequency stepped each period
   always @(posedge clk) begin
      zc_ff <= 3'h0;
      cnt <= cnt + 16'h0001;
      if (cnt >= per - 16'h0001) begin
         cnt <= 16'h0000;
         zc_ff <= 3'h7;
         freq_ff <= freq_ff - step;
      end
   end
endmodule : fre_meas_model
`default_nettype wire

//--- test/tb_frequency_rocof_vector_surge_element.sv
// self-checking bench of the frequency element
`timescale 1ns/1ps
`default_nettype none
module tb_frequency_rocof_vector_surge_element;
   logic MCLK = 0, SRST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, EXT_BLOCK = 0, WB_ACK_O, ALARM, TRIP;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'hf;
   logic [31:0] WB_DAT_I = 32'h00000000, WB_DAT_O, rnd;
   logic [15:0] per = 16'h0032, step = 16'h0000, volt = 16'h0800, freq, vout;
   logic [2:0] zc;
   logic [31:0] exp_q[$];
   int error_cnt = 0, num_checks = 0, seed = 60;
   fre_element #(.TICK_CYC(10), .DETECT_CYC(200), .WIN_MAX(10)) fre_element_i (.MCLK(MCLK), .SRST(SRST),
      .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
      .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FREQ_A_B(freq), .FREQ_B_C(freq),
      .FREQ_C_A(freq), .VOLT_PHASE_A_B(vout), .VOLT_PHASE_B_C(vout), .VOLT_PHASE_C_A(vout), .ZERO_CROSS(zc),
      .EXT_BLOCK(EXT_BLOCK), .ALARM(ALARM), .TRIP(TRIP));
   fre_meas_model fre_meas_model_i (.clk(MCLK), .per(per), .step(step), .volt(volt), .freq(freq), .vout(vout),
      .zc(zc));
   initial forever #5 MCLK = ~MCLK;
   task summarize;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // classic single cycle, held until ack is sampled
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= we ? d : 32'h00000000;
      if (!we) exp_q.push_back(d);
      do begin @(posedge MCLK); n++; end while (WB_ACK_O !== 1'b1 && n < 50);
      if (n >= 50) begin error_cnt++; summarize(); end
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask : wb
   // read data compared with the oldest note
   always @(posedge MCLK) begin
      if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
         num_checks++;
         if (exp_q.size() == 0 || WB_DAT_O !== exp_q[0]) begin
            error_cnt++;
            $display("Error rdata adr %h exp %h got %h", WB_ADR_I, exp_q[0], WB_DAT_O);
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   // bounded wait for an alarm and trip pair
   task wt(input logic a, input logic t, input int lim);
      int n;
      n = 0;
      while ({ALARM, TRIP} !== {a, t} && n < lim) begin @(posedge MCLK); n++; end
      num_checks++;
      if ({ALARM, TRIP} !== {a, t}) begin error_cnt++; $display("Error outputs exp %b%b got %b%b", a, t, ALARM, TRIP); end
   endtask : wt
   initial begin
      repeat (5) @(posedge MCLK);
      SRST <= 1'b0;
      wb(0, 8'h00, 32'h00000200);
      wb(0, 8'h20, 32'h00ffffff);
      wb(1, 8'h3c, 32'h12345678);
      wb(0, 8'h3c, 32'h00000000);
      rnd = $random(seed);
      wb(1, 8'h04, rnd);
      wb(0, 8'h04, rnd & 32'h0000ffff);
      wb(1, 8'h04, 32'h00000f00);
      wb(1, 8'h0c, 32'h00000004);
      wb(1, 8'h10, 32'h00000100);
      wb(1, 8'h14, 32'h00000003);
      wb(1, 8'h20, 32'h00000005);
      step <= 16'h0010;
      wb(1, 8'h00, 32'h00000201);
      repeat (1200) @(posedge MCLK);
      wt(0, 0, 1);
      wb(1, 8'h00, 32'h00000209);
      wt(1, 0, 400);
      wt(1, 1, 200);
      wt(1, 1, 1);
      EXT_BLOCK <= 1'b1;
      wt(0, 0, 3);
      EXT_BLOCK <= 1'b0;
      step <= 16'h0000;
      repeat (200) @(posedge MCLK);
      wt(0, 0, 1);
      step <= 16'h0010;
      volt <= 16'h0050;
      repeat (300) @(posedge MCLK);
      wt(0, 0, 1);
      volt <= 16'h0800;
      step <= 16'h0000;
      repeat (150) @(posedge MCLK);
      wb(1, 8'h18, 32'h00000020);
      wb(1, 8'h1c, 32'h00000005);
      wb(1, 8'h00, 32'h00000203);
      wt(1, 0, 10);
      wt(0, 0, 100);
      step <= 16'h0010;
      repeat (200) @(posedge MCLK);
      wt(0, 0, 1);
      wb(1, 8'h1c, 32'h00000020);
      wb(1, 8'h04, 32'h00000000);
      wb(1, 8'h04, 32'h00000f00);
      wt(1, 1, 300);
      wb(0, 8'h24, 32'h00000003);
      step <= 16'h0000;
      wb(1, 8'h00, 32'h00000205);
      repeat (300) @(posedge MCLK);
      wt(0, 0, 1);
      per <= 16'h003c;
      wt(1, 1, 200);
      summarize();
   end
endmodule : tb_frequency_rocof_vector_surge_element
`default_nettype wire
